// ### inc/io_bus_pkg.sv
package io_bus_pkg;
	localparam int DATA_W = 18;
	localparam int ADDR_W = 15;
	localparam int DEV_W = 6;
	localparam int OP_W = 3;
	localparam int CABLE_SIGNALS = 72;
	localparam int FIFO_DEPTH = 16;
	// timing of the sync pulse train
	localparam int CLK_NS = 10;
	localparam int SYNC_PERIOD_NS = 1000;
	localparam int SYNC_CYCLES = SYNC_PERIOD_NS / CLK_NS;
	// io transfer instruction sub-operations
	localparam logic [OP_W-1:0] OP_LD_CMD = 3'h0;
	localparam logic [OP_W-1:0] OP_RD_STAT = 3'h1;
	localparam logic [OP_W-1:0] OP_SKIP = 3'h2;
	localparam logic [OP_W-1:0] OP_LD_CA = 3'h3;
	localparam logic [OP_W-1:0] OP_LD_WC = 3'h4;
	localparam logic [OP_W-1:0] OP_CLR_FLAG = 3'h5;
	// command register bits
	localparam int CMD_GO = 0;
	localparam int CMD_SINGLE = 1;
	localparam int CMD_INPUT = 2;
	localparam int CMD_API = 3;
	// status word bits
	localparam int ST_FLAG = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_FULL = 2;
	localparam int ST_EMPTY = 3;
	localparam logic [DATA_W-1:0] ZERO_WORD = 18'h0;
	// processor to devices, broadcast
	typedef struct packed {
		logic sync;
		logic pwr_clr;
		logic io_transfer_instruction;
		logic [OP_W-1:0] iop;
		logic [DEV_W-1:0] dev_sel;
		logic [DATA_W-1:0] data;
		logic dch_gr;
		logic api_gr;
		logic ack;
		logic wc_ovf;
	} bcast_t;
	// devices to processor, or-combined on the cable
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [ADDR_W-1:0] addr;
		logic dch_rq;
		logic api_rq;
		logic int_rq;
		logic skip_rq;
		logic rd_rq;
		logic sing_cy;
	} up_t;
endpackage

// ### inc/io_bus_if.sv
`timescale 1ns/1ps
interface io_bus_if;
	io_bus_pkg::bcast_t bc;
	io_bus_pkg::up_t up;
	logic dch_en;
	logic api_en;
	modport proc(output bc, output dch_en, output api_en, input up);
	modport dev(input bc, input dch_en, input api_en, output up);
endinterface

// ### hw/io_dev.sv
`timescale 1ns/1ps
// word buffer between user side and bus
module io_fifo #(
	parameter int W = 18,
	parameter int DEPTH = 16
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_valid,
	input wire logic [W-1:0] i_data,
	output logic o_ready,
	output logic o_valid,
	output logic [W-1:0] o_data,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_st_t;
	fifo_st_t s;
	fifo_st_t next_s;
	logic push;
	logic pop;

	// handshakes from occupancy
	assign o_ready = s.cnt != (AW+1)'(DEPTH);
	assign o_valid = s.cnt != '0;
	assign o_data = s.mem[s.rp];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	// pointer and count update
	always_comb
	begin
		next_s = s;
		if (push)
		begin
			next_s.mem[s.wp] = i_data;
			next_s.wp = s.wp + 1'b1;
		end
		if (pop)
			next_s.rp = s.rp + 1'b1;
		if (push && !pop)
			next_s.cnt = s.cnt + 1'b1;
		else if (pop && !push)
			next_s.cnt = s.cnt - 1'b1;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			s <= '0;
		else if (i_ce)
			s <= next_s;
	end
endmodule

// peripheral end of the chained bus
module io_dev #(
	parameter logic [io_bus_pkg::DEV_W-1:0] DEV_NUM = 6'h11,
	parameter logic [io_bus_pkg::DEV_W-1:0] TRAP_NUM = 6'h21
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	io_bus_if.dev bus,
	input wire logic i_done,
	input wire logic i_in_valid,
	input wire logic [io_bus_pkg::DATA_W-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [io_bus_pkg::DATA_W-1:0] o_out_data,
	input wire logic i_out_ready,
	output logic [io_bus_pkg::DATA_W-1:0] o_cmd,
	output io_bus_pkg::bcast_t o_next_bc,
	output logic o_next_dch_en,
	output logic o_next_api_en
);
	typedef struct packed {
		logic [io_bus_pkg::DATA_W-1:0] cmd;
		logic [io_bus_pkg::ADDR_W-1:0] ca;
		logic [io_bus_pkg::DATA_W-1:0] wc;
		logic [io_bus_pkg::DATA_W-1:0] word;
		logic flag;
		logic dch_req;
		logic api_req;
		logic api_sent;
		logic ena;
		logic api_ena;
		logic rsp_stat;
		logic rsp_skip;
		io_bus_pkg::up_t up;
	} dev_st_t;
	dev_st_t s;
	dev_st_t next_s;
	logic f_in_valid;
	logic [io_bus_pkg::DATA_W-1:0] f_in_data;
	logic f_in_ready;
	logic f_out_valid;
	logic [io_bus_pkg::DATA_W-1:0] f_out_data;
	logic f_out_ready;
	logic bus_push;
	logic bus_pop;
	logic indir;
	logic sel;
	logic [io_bus_pkg::DATA_W-1:0] stat;

	// enable passes only past a device not asking
	function automatic logic chain(input logic en, input logic req);
		chain = en && !req;
	endfunction

	assign indir = s.cmd[io_bus_pkg::CMD_INPUT];
	assign sel = bus.bc.io_transfer_instruction && bus.bc.dev_sel == DEV_NUM;

	// buffer faces user or bus by direction
	assign f_in_valid = indir ? i_in_valid : bus_push;
	assign f_in_data = indir ? i_in_data : bus.bc.data;
	assign f_out_ready = indir ? bus_pop : i_out_ready;
	assign o_in_ready = indir && f_in_ready;
	assign o_out_valid = !indir && f_out_valid;
	assign o_out_data = f_out_data;
	assign bus_pop = bus.bc.dch_gr && s.dch_req && indir;
	assign bus_push = bus.bc.ack && s.ena && !indir;

	io_fifo #(
		.W(io_bus_pkg::DATA_W),
		.DEPTH(io_bus_pkg::FIFO_DEPTH)
	) buffer (
		.i_clock(i_clock),
		.i_rst(i_rst || bus.bc.pwr_clr),
		.i_ce(i_ce),
		.i_valid(f_in_valid),
		.i_data(f_in_data),
		.o_ready(f_in_ready),
		.o_valid(f_out_valid),
		.o_data(f_out_data),
		.i_ready(f_out_ready)
	);

	// status word
	always_comb
	begin
		stat = io_bus_pkg::ZERO_WORD;
		stat[io_bus_pkg::ST_FLAG] = s.flag;
		stat[io_bus_pkg::ST_BUSY] = s.cmd[io_bus_pkg::CMD_GO];
		stat[io_bus_pkg::ST_FULL] = !f_in_ready;
		stat[io_bus_pkg::ST_EMPTY] = !f_out_valid;
	end

	// outgoing cable and chain
	assign bus.up = s.up;
	assign o_next_bc = bus.bc;
	assign o_next_dch_en = chain(bus.dch_en, s.dch_req);
	assign o_next_api_en = chain(bus.api_en, s.api_req);
	assign o_cmd = s.cmd;

	// request, transfer and instruction handling
	always_comb
	begin
		next_s = s;
		next_s.api_ena = 1'b0;
		next_s.rsp_stat = 1'b0;
		next_s.rsp_skip = 1'b0;
		// program instructions for this device
		if (sel)
		begin
			unique case (bus.bc.iop)
				io_bus_pkg::OP_LD_CMD: next_s.cmd = bus.bc.data;
				io_bus_pkg::OP_LD_CA:
					next_s.ca = bus.bc.data[io_bus_pkg::ADDR_W-1:0];
				io_bus_pkg::OP_LD_WC: next_s.wc = bus.bc.data;
				io_bus_pkg::OP_RD_STAT:
				begin
					next_s.rsp_stat = 1'b1;
					next_s.word = stat;
				end
				io_bus_pkg::OP_SKIP: next_s.rsp_skip = s.flag;
				io_bus_pkg::OP_CLR_FLAG:
				begin
					next_s.flag = 1'b0;
					next_s.api_sent = 1'b0;
				end
				default: ;
			endcase
		end
		// data channel request on sync, gated by enable
		if (bus.bc.sync && bus.dch_en && !s.dch_req && !s.ena
			&& next_s.cmd[io_bus_pkg::CMD_GO]
			&& (indir ? f_out_valid : f_in_ready))
			next_s.dch_req = 1'b1;
		// interrupt request on sync
		if (bus.bc.sync && bus.api_en && s.flag && !s.api_sent
			&& s.cmd[io_bus_pkg::CMD_API])
			next_s.api_req = 1'b1;
		// grants
		if (bus.bc.dch_gr && s.dch_req)
		begin
			next_s.dch_req = 1'b0;
			next_s.ena = 1'b1;
			if (indir)
				next_s.word = f_out_data;
		end
		if (bus.bc.api_gr && s.api_req)
		begin
			next_s.api_req = 1'b0;
			next_s.api_sent = 1'b1;
			next_s.api_ena = 1'b1;
		end
		// word taken, step address and count in single cycle mode
		if (bus.bc.ack && s.ena)
		begin
			next_s.ena = 1'b0;
			if (s.cmd[io_bus_pkg::CMD_SINGLE])
			begin
				next_s.ca = s.ca + 1'b1;
				next_s.wc = s.wc + 1'b1;
			end
			if (s.cmd[io_bus_pkg::CMD_SINGLE] ? next_s.wc == '0
				: bus.bc.wc_ovf)
			begin
				next_s.cmd[io_bus_pkg::CMD_GO] = 1'b0;
				next_s.flag = 1'b1;
			end
		end
		// end of operation, set wins over clear flag, power clear wins over both
		if (i_done)
			next_s.flag = 1'b1;
		if (bus.bc.pwr_clr)
			next_s = '0;
		// cable image, zeros while idle apart from int_rq while the flag is set and CMD_API is clear
		next_s.up = '0;
		next_s.up.dch_rq = next_s.dch_req;
		next_s.up.api_rq = next_s.api_req;
		next_s.up.int_rq = next_s.flag
			&& !next_s.cmd[io_bus_pkg::CMD_API];
		next_s.up.skip_rq = next_s.rsp_skip;
		if (next_s.rsp_stat)
			next_s.up.data = next_s.word;
		if (next_s.ena)
		begin
			next_s.up.rd_rq = indir;
			next_s.up.sing_cy = next_s.cmd[io_bus_pkg::CMD_SINGLE];
			if (indir)
				next_s.up.data = next_s.word;
			if (next_s.cmd[io_bus_pkg::CMD_SINGLE])
				next_s.up.addr = next_s.ca;
			else
				next_s.up.addr = 15'(DEV_NUM);
		end
		if (next_s.api_ena)
			next_s.up.addr = 15'(TRAP_NUM);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			s <= '0;
		else if (i_ce)
			s <= next_s;
	end
endmodule

// ### hw/io_proc.sv
`timescale 1ns/1ps
// processor end: sync, grants, instructions, tables
module io_proc (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	io_bus_if.proc bus,
	input wire logic i_pwr_clr,
	input wire logic i_iot_req,
	input wire logic [io_bus_pkg::DEV_W-1:0] i_iot_dev,
	input wire logic [io_bus_pkg::OP_W-1:0] i_iot_op,
	input wire logic [io_bus_pkg::DATA_W-1:0] i_iot_data,
	output logic o_iot_ready,
	output logic o_iot_done,
	output logic [io_bus_pkg::DATA_W-1:0] o_iot_rdata,
	output logic o_iot_skip,
	input wire logic i_tab_we,
	input wire logic i_tab_wc,
	input wire logic [io_bus_pkg::DEV_W-1:0] i_tab_dev,
	input wire logic [io_bus_pkg::DATA_W-1:0] i_tab_data,
	output logic [io_bus_pkg::ADDR_W-1:0] o_mem_addr,
	output logic o_mem_we,
	output logic [io_bus_pkg::DATA_W-1:0] o_mem_wdata,
	input wire logic [io_bus_pkg::DATA_W-1:0] i_mem_rdata,
	output logic o_trap_valid,
	output logic [io_bus_pkg::DEV_W-1:0] o_trap,
	output logic o_prog_int
);
	localparam int NDEV = 2 ** io_bus_pkg::DEV_W;
	localparam int DW = io_bus_pkg::DEV_W;
	typedef enum logic [3:0] {
		P_IDLE = 4'h0,
		P_IOT = 4'h1,
		P_IOT_R = 4'h2,
		P_GRANT = 4'h3,
		P_ADDR = 4'h4,
		P_MEM = 4'h5,
		P_API_W = 4'h6,
		P_API = 4'h7
	} pstate_t;
	typedef struct packed {
		pstate_t st;
		io_bus_pkg::bcast_t bc;
		logic [7:0] div;
		logic [NDEV-1:0][io_bus_pkg::ADDR_W-1:0] ca;
		logic [NDEV-1:0][io_bus_pkg::DATA_W-1:0] wc;
		io_bus_pkg::up_t cap;
		logic iot_done;
		logic [io_bus_pkg::DATA_W-1:0] rdata;
		logic skip;
		logic [io_bus_pkg::ADDR_W-1:0] mem_addr;
		logic mem_we;
		logic [io_bus_pkg::DATA_W-1:0] mem_wdata;
		logic trap_valid;
		logic [DW-1:0] trap;
		logic prog_int;
	} proc_st_t;
	proc_st_t s;
	proc_st_t next_s;
	logic [DW-1:0] dev;

	assign dev = s.cap.addr[DW-1:0];
	assign bus.bc = s.bc;
	assign bus.dch_en = 1'b1;
	assign bus.api_en = 1'b1;
	assign o_iot_ready = s.st == P_IDLE && !bus.up.dch_rq && !bus.up.api_rq;
	assign o_iot_done = s.iot_done;
	assign o_iot_rdata = s.rdata;
	assign o_iot_skip = s.skip;
	assign o_mem_addr = s.mem_addr;
	assign o_mem_we = s.mem_we;
	assign o_mem_wdata = s.mem_wdata;
	assign o_trap_valid = s.trap_valid;
	assign o_trap = s.trap;
	assign o_prog_int = s.prog_int;

	// sequencing of the bus
	always_comb
	begin
		next_s = s;
		next_s.bc.sync = 1'b0;
		next_s.bc.io_transfer_instruction = 1'b0;
		next_s.bc.dch_gr = 1'b0;
		next_s.bc.api_gr = 1'b0;
		next_s.bc.ack = 1'b0;
		next_s.bc.wc_ovf = 1'b0;
		next_s.bc.pwr_clr = i_pwr_clr;
		next_s.iot_done = 1'b0;
		next_s.mem_we = 1'b0;
		next_s.trap_valid = 1'b0;
		next_s.prog_int = bus.up.int_rq;
		// sync pulse train
		next_s.div = s.div + 1'b1;
		if (s.div == 8'(io_bus_pkg::SYNC_CYCLES - 1))
		begin
			next_s.div = '0;
			next_s.bc.sync = 1'b1;
		end
		// program loads the channel tables
		if (i_tab_we)
		begin
			if (i_tab_wc)
				next_s.wc[i_tab_dev] = i_tab_data;
			else
				next_s.ca[i_tab_dev] =
					i_tab_data[io_bus_pkg::ADDR_W-1:0];
		end
		unique case (s.st)
			P_IDLE:
				if (bus.up.dch_rq)
				begin
					next_s.bc.dch_gr = 1'b1;
					next_s.st = P_GRANT;
				end
				else if (bus.up.api_rq)
				begin
					next_s.bc.api_gr = 1'b1;
					next_s.st = P_API_W;
				end
				else if (i_iot_req)
				begin
					next_s.bc.io_transfer_instruction = 1'b1;
					next_s.bc.dev_sel = i_iot_dev;
					next_s.bc.iop = i_iot_op;
					next_s.bc.data = i_iot_data;
					next_s.st = P_IOT;
				end
			P_IOT: next_s.st = P_IOT_R;
			P_IOT_R:
			begin
				next_s.rdata = bus.up.data;
				next_s.skip = bus.up.skip_rq;
				next_s.iot_done = 1'b1;
				next_s.st = P_IDLE;
			end
			P_GRANT: next_s.st = P_ADDR;
			P_ADDR:
			begin
				next_s.cap = bus.up;
				next_s.mem_addr = bus.up.sing_cy ? bus.up.addr
					: s.ca[bus.up.addr[DW-1:0]];
				next_s.mem_we = bus.up.rd_rq;
				next_s.mem_wdata = bus.up.data;
				next_s.st = P_MEM;
			end
			P_MEM:
			begin
				next_s.bc.data = i_mem_rdata;
				next_s.bc.ack = 1'b1;
				if (!s.cap.sing_cy)
				begin
					next_s.ca[dev] = s.ca[dev] + 1'b1;
					next_s.wc[dev] = s.wc[dev] + 1'b1;
					next_s.bc.wc_ovf = next_s.wc[dev] == '0;
				end
				next_s.st = P_IDLE;
			end
			P_API_W: next_s.st = P_API;
			P_API:
			begin
				next_s.trap = bus.up.addr[DW-1:0];
				next_s.trap_valid = 1'b1;
				next_s.st = P_IDLE;
			end
			default: next_s.st = P_IDLE;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			s <= '0;
		else if (i_ce)
			s <= next_s;
	end
endmodule

// ### testbench/io_bus_properties.sv
`timescale 1ns/1ps
// bus rules seen between the two ends
module io_bus_properties #(
	parameter logic [io_bus_pkg::DEV_W-1:0] DEV_NUM = 6'h11,
	parameter logic [io_bus_pkg::DEV_W-1:0] TRAP_NUM = 6'h21
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire io_bus_pkg::bcast_t bc,
	input wire io_bus_pkg::up_t up,
	input wire logic dch_en,
	input wire logic api_en
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	// one instruction pulse, selection held after it
	iot_pulse_a: assert property (bc.io_transfer_instruction |=> !bc.io_transfer_instruction && $stable(bc.dev_sel))
		else $error("instruction pulse longer than one cycle");
	// other device numbers get no answer
	quiet_dev_a: assert property (bc.io_transfer_instruction && bc.dev_sel != DEV_NUM
		|=> up.data == 18'h0 && !up.skip_rq)
		else $error("answer to a foreign device number");
	// data lines zero unless answering or sending
	bus_zero_a: assert property (up.data != 18'h0
		|-> $past(bc.io_transfer_instruction) || up.rd_rq)
		else $error("data lines driven while idle");
	// data channel requests start only after a sync pulse
	req_sync_a: assert property ($rose(up.dch_rq)
		|-> $past(bc.sync) || $past(bc.sync, 2))
		else $error("request not on a sync pulse");
	// address group stands through the grant
	addr_hold_a: assert property (bc.dch_gr
		|=> ##1 $stable(up.addr) [*2])
		else $error("address moved during transfer");
	// interrupt grant answered with trap number
	trap_num_a: assert property (bc.api_gr
		|=> up.addr == 15'(TRAP_NUM))
		else $error("wrong trap number");
	// power clear drops every request
	pwr_clr_a: assert property (bc.pwr_clr [*2]
		|=> !up.dch_rq && !up.api_rq && !up.int_rq)
		else $error("request survives power clear");
	// overflow comes only with an acknowledge
	ovf_ack_a: assert property (bc.wc_ovf |-> bc.ack)
		else $error("overflow without acknowledge");
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
	localparam logic [5:0] DEV = 6'h11;
	localparam logic [5:0] TRAP = 6'h21;
	logic clk, rst, pwr_clr, iot_req, iot_ready, iot_done, iot_skip;
	logic [5:0] iot_dev, tab_dev, trap;
	logic [2:0] iot_op;
	logic [17:0] iot_data, iot_rdata, tab_data, mem_wdata, mem_rdata;
	logic [17:0] in_data, out_data, cmd;
	logic tab_we, tab_wc, mem_we, trap_valid, prog_int, done, seen;
	logic in_valid, in_ready, out_valid, out_ready, ndch, napi;
	logic [14:0] mem_addr;
	logic [14:0] wa[8];
	logic [17:0] wd[8];
	io_bus_pkg::bcast_t nbc;
	int bad_count, checks_done, wn, i;
	io_bus_if bus();
	io_proc u_io_proc(.i_clock(clk), .i_rst(rst), .i_ce(1'b1), .bus(bus),
		.i_pwr_clr(pwr_clr), .i_iot_req(iot_req), .i_iot_dev(iot_dev),
		.i_iot_op(iot_op), .i_iot_data(iot_data), .o_iot_ready(iot_ready),
		.o_iot_done(iot_done), .o_iot_rdata(iot_rdata), .o_iot_skip(iot_skip),
		.i_tab_we(tab_we), .i_tab_wc(tab_wc), .i_tab_dev(tab_dev),
		.i_tab_data(tab_data), .o_mem_addr(mem_addr), .o_mem_we(mem_we),
		.o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata),
		.o_trap_valid(trap_valid), .o_trap(trap), .o_prog_int(prog_int));
	io_dev #(.DEV_NUM(DEV), .TRAP_NUM(TRAP)) u_io_dev(.i_clock(clk),
		.i_rst(rst), .i_ce(1'b1), .bus(bus), .i_done(done),
		.i_in_valid(in_valid), .i_in_data(in_data), .o_in_ready(in_ready),
		.o_out_valid(out_valid), .o_out_data(out_data),
		.i_out_ready(out_ready), .o_cmd(cmd), .o_next_bc(nbc),
		.o_next_dch_en(ndch), .o_next_api_en(napi));
	io_bus_properties #(.DEV_NUM(DEV), .TRAP_NUM(TRAP)) u_io_bus_properties(
		.i_clock(clk), .i_rst(rst), .bc(bus.bc), .up(bus.up),
		.dch_en(bus.dch_en), .api_en(bus.api_en));
	// memory word follows its address
	assign mem_rdata = {3'h5, mem_addr};
	// log memory writes and a trapped interrupt enable
	always @(posedge clk)
	begin
		if (mem_we && wn < 8)
		begin
			wa[wn] <= mem_addr;
			wd[wn] <= mem_wdata;
			wn <= wn + 1;
		end
		if (napi === 1'b0)
			seen <= 1'b1;
	end
	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp)
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		if (got !== exp)
			bad_count++;
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return iot_ready === 1'b1;
			1: return iot_done === 1'b1;
			2: return in_ready === 1'b1;
			3: return wn == 2;
			4: return trap_valid === 1'b1;
			default: return out_valid === 1'b1;
		endcase
	endfunction
	// bounded wait, sampled at falling edges
	task wait_on(input int k);
		int n;
		n = 0;
		@(negedge clk);
		while (!sig(k))
		begin
			n++;
			if (n > 1000)
				bad_count++;
			if (n > 1000)
				stop_test;
			@(negedge clk);
		end
	endtask
	task io_transfer_instruction(input logic [5:0] d, input logic [2:0] op, input logic [17:0] v);
		@(posedge clk);
		iot_req <= 1'b1;
		iot_dev <= d;
		iot_op <= op;
		iot_data <= v;
		wait_on(0);
		@(posedge clk);
		iot_req <= 1'b0;
		wait_on(1);
	endtask
	task push(input logic [17:0] v);
		@(posedge clk);
		in_valid <= 1'b1;
		in_data <= v;
		wait_on(2);
		@(posedge clk);
		in_valid <= 1'b0;
	endtask
	task tab(input logic wc, input logic [17:0] v);
		@(posedge clk);
		tab_we <= 1'b1;
		tab_wc <= wc;
		tab_dev <= DEV;
		tab_data <= v;
		@(posedge clk);
		tab_we <= 1'b0;
	endtask
	// main sequence
	initial
	begin
		{pwr_clr, iot_req, iot_dev, iot_op, iot_data, tab_we, tab_wc} = '0;
		{tab_dev, tab_data, done, seen, in_valid, in_data} = '0;
		{bad_count, checks_done, wn} = '0;
		out_ready = 1'b1;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		io_transfer_instruction(6'h12, io_bus_pkg::OP_LD_CMD, 18'h3ff);
		chk(cmd, 18'h0);
		io_transfer_instruction(DEV, io_bus_pkg::OP_LD_CMD, 18'h6);
		chk(cmd, 18'h6);
		io_transfer_instruction(DEV, io_bus_pkg::OP_RD_STAT, 18'h0);
		chk(iot_rdata, 18'h8);
		$display("test command done");
		io_transfer_instruction(DEV, io_bus_pkg::OP_LD_CA, 18'h100);
		io_transfer_instruction(DEV, io_bus_pkg::OP_LD_WC, 18'h3fffe);
		for (i = 0; i < 3; i++)
			push(18'h30000 + 18'(i));
		io_transfer_instruction(DEV, io_bus_pkg::OP_LD_CMD, 18'h7);
		wait_on(3);
		for (i = 0; i < 2; i++)
		begin
			chk({3'h0, wa[i]}, 18'h100 + 18'(i));
			chk(wd[i], 18'h30000 + 18'(i));
		end
		io_transfer_instruction(DEV, io_bus_pkg::OP_RD_STAT, 18'h0);
		chk(iot_rdata, 18'h1);
		chk({17'h0, prog_int}, 18'h1);
		io_transfer_instruction(DEV, io_bus_pkg::OP_SKIP, 18'h0);
		chk({17'h0, iot_skip}, 18'h1);
		chk({12'h0, nbc.dev_sel}, {12'h0, DEV});
		chk({17'h0, ndch}, 18'h1);
		$display("test single cycle done");
		@(posedge clk);
		pwr_clr <= 1'b1;
		repeat (3) @(posedge clk);
		pwr_clr <= 1'b0;
		io_transfer_instruction(DEV, io_bus_pkg::OP_RD_STAT, 18'h0);
		chk(iot_rdata, 18'h8);
		chk({17'h0, prog_int}, 18'h0);
		$display("test power clear done");
		io_transfer_instruction(DEV, io_bus_pkg::OP_LD_CMD, 18'h8);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		wait_on(4);
		chk({12'h0, trap}, {12'h0, TRAP});
		chk({17'h0, seen}, 18'h1);
		io_transfer_instruction(DEV, io_bus_pkg::OP_CLR_FLAG, 18'h0);
		$display("test interrupt done");
		tab(1'b0, 18'h200);
		tab(1'b1, 18'h3ffff);
		io_transfer_instruction(DEV, io_bus_pkg::OP_LD_CMD, 18'h1);
		wait_on(5);
		chk(out_data, {3'h5, 15'h200});
		$display("test multi cycle done");
		stop_test;
	end
endmodule
